// >>> vgp_pkg.sv
`default_nettype none
// ****************************************************************************
// Shared constants for the port configuration register bank.
// ****************************************************************************
package vgp_pkg;
    // Register offsets within the board window (byte addresses).
    localparam logic [9:0] OFS_LINE_STATUS_A = 10'h101;
    localparam logic [9:0] OFS_PAGE_A        = 10'h109;
    localparam logic [9:0] OFS_LINE_STATUS_B = 10'h301;
    localparam logic [9:0] OFS_PAGE_B        = 10'h309;
    localparam logic [9:0] OFS_CONFIG_TWO_A  = 10'h105;
    localparam logic [9:0] OFS_CONFIG_TWO_B  = 10'h305;
    // Field positions inside config_two.
    localparam int BIT_SYS_CTRL  = 0;
    localparam int BIT_SOFT_RST  = 1;
    localparam int BIT_PRIV_ONLY = 2;
    // Values after reset.
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic       SC_RESET   = 1'b0;
    // Register number codes used by the decoder.
    typedef enum logic [2:0] {
        VGP_SEL_NONE = 3'b000,
        VGP_SEL_STAT = 3'b001,
        VGP_SEL_PAGE = 3'b010,
        VGP_SEL_CFG  = 3'b011
    } vgp_sel_e;
endpackage
`default_nettype wire

// >>> vgp_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************************
// Address decoder: splits a board offset into a port and a register.
// ****************************************************************************
module vgp_addr_decode (
    // Address in.
    input  wire logic [9:0]       addr_in,
    // Decoded target.
    output logic                  port_b_out,
    output vgp_pkg::vgp_sel_e     sel_out
);
    // The two ports share low offsets; bit 9 picks the port.
    always_comb begin
        port_b_out = addr_in[9];
        case ({1'b0, addr_in[8:0]})
            vgp_pkg::OFS_LINE_STATUS_A: sel_out = vgp_pkg::VGP_SEL_STAT;
            vgp_pkg::OFS_PAGE_A:        sel_out = vgp_pkg::VGP_SEL_PAGE;
            vgp_pkg::OFS_CONFIG_TWO_A:  sel_out = vgp_pkg::VGP_SEL_CFG;
            default:                    sel_out = vgp_pkg::VGP_SEL_NONE;
        endcase
    end
endmodule // vgp_addr_decode
`default_nettype wire

// >>> vgp_port_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - privileged_access_only 1 means supervisor cycles only.
// - Privilege bit loads jumper value on reset.
// - Soft reset clears own port, shared if jumper.
// - board_soft_reset bit drives internal reset level.
// - SYSRESET forces the same local reset.
// - system_controller_select 1 makes port controller.
// - Controller select cleared by any reset.
// - Page drives upper address during extended DMA.
// - One page register shared by both ports.
// - Per-port read-only status from chip pins.
// - Status read on D7-D0, active high.
// - Status valid only where transceiver observes.
// - config_two write-only, per-port offset.
module vgp_port_config_regs (
    // Clock and reset.
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // Board jumpers and SYSRESET.
    input  wire logic       privilege_default_jumper_in,
    input  wire logic       common_reset_jumper_in,
    input  wire logic       sysreset_n_in,
    // Register access port.
    input  wire logic [9:0] addr_in,
    input  wire logic       ds_in,
    input  wire logic       write_in,
    input  wire logic       supervisor_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    output logic            rdata_oe_out,
    output logic            dtack_out,
    // Line status pins per port.
    input  wire logic [7:0] bus_line_status_a_in,
    input  wire logic [7:0] bus_line_status_b_in,
    // DMA address drive.
    input  wire logic       extended_mode_in,
    input  wire logic       dma_addr_drive_in,
    output logic      [7:0] upper_address_out,
    output logic            upper_address_oe_out,
    // Control outputs.
    output logic            privileged_access_only_out,
    output logic            system_controller_select_a_out,
    output logic            system_controller_select_b_out,
    output logic            port_reset_a_out,
    output logic            port_reset_b_out,
    output logic            common_reset_out
);
    // ************************************************************************
    // Decode.
    // ************************************************************************
    logic              port_b;     // Target port.
    vgp_pkg::vgp_sel_e sel;        // Target register.

    vgp_addr_decode u_dec (
        .addr_in    (addr_in),
        .port_b_out (port_b),
        .sel_out    (sel)
    );

    // Cycles only take effect on a strobe edge, so a held strobe writes once.
    logic ds_q;                    // Strobe from the previous cycle.
    logic strobe;                  // Leading edge of the data strobe.
    logic access_ok;               // Privilege check passes.
    logic priv;                    // Supervisor-only flag.
    // The gate reads the internal bit, not the output flop, so a write that sets
    // supervisor-only already refuses the very next user cycle.
    // privilege gate
    assign access_ok = supervisor_in || !priv;
    assign strobe    = ds_in && !ds_q && access_ok;

    // ************************************************************************
    // Register state.
    // ************************************************************************
    logic       next_priv;
    logic [1:0] sc;                // System controller select, per port.
    logic [1:0] next_sc;
    logic [1:0] soft_rst;          // Soft reset bit, per port.
    logic [1:0] next_soft_rst;
    logic [7:0] page;              // Shared upper address page.
    logic [7:0] next_page;
    logic       strap_done;        // Jumper caught after reset release.
    logic       next_strap_done;
    logic       sys_rst;           // SYSRESET active.
    logic [1:0] port_rst;          // Effective per-port reset.

    // SYSRESET is taken as synchronous and does the same work as the soft reset bits.
    // sysreset forces reset
    assign sys_rst = !sysreset_n_in;
    assign port_rst[0] = soft_rst[0] || sys_rst;
    assign port_rst[1] = soft_rst[1] || sys_rst;

    // Next-state for the configuration and page registers.
    always_comb begin
        next_priv       = priv;
        next_sc         = sc;
        next_soft_rst   = soft_rst;
        next_page       = page;
        next_strap_done = 1'b1;
        // The jumper is read on the first edge after reset and on every SYSRESET,
        // so moving it while the board runs has no effect until the next reset.
        // jumper default load
        if (!strap_done || sys_rst) begin
            next_priv = privilege_default_jumper_in;
        end
        if (sys_rst) begin
            next_sc       = {2{vgp_pkg::SC_RESET}};
            next_soft_rst = 2'b00;
        end else if (strobe && write_in) begin
            if (sel == vgp_pkg::VGP_SEL_CFG) begin
                // Bits 7 to 3 belong to functions outside this block and are dropped.
                // reserved bits ignored
                next_priv = wdata_in[vgp_pkg::BIT_PRIV_ONLY];
                next_soft_rst[port_b] = wdata_in[vgp_pkg::BIT_SOFT_RST];
                next_sc[port_b] = wdata_in[vgp_pkg::BIT_SYS_CTRL];
            end
            if (sel == vgp_pkg::VGP_SEL_PAGE) begin
                next_page = wdata_in;
            end
        end
        if (soft_rst[0]) begin
            next_sc[0] = vgp_pkg::SC_RESET;
        end
        if (soft_rst[1]) begin
            next_sc[1] = vgp_pkg::SC_RESET;
        end
    end

    // Register the configuration state.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            priv       <= 1'b1;
            sc         <= {2{vgp_pkg::SC_RESET}};
            soft_rst   <= 2'b00;
            page       <= vgp_pkg::PAGE_RESET;
            strap_done <= 1'b0;
            ds_q       <= 1'b0;
        end else begin
            priv       <= next_priv;
            sc         <= next_sc;
            soft_rst   <= next_soft_rst;
            page       <= next_page;
            strap_done <= next_strap_done;
            ds_q       <= ds_in;
        end
    end

    // ************************************************************************
    // Read path and outputs.
    // ************************************************************************
    logic [7:0] next_rdata;
    logic       next_rdata_oe;
    logic       next_dtack;
    logic       next_common;
    logic [7:0] next_upper;
    logic       next_upper_oe;

    // A write to the status register is acknowledged but has no effect, and a read
    // of a write-only register is acknowledged with the data pins left undriven.
    // Outputs are registered so every pin comes straight from a flop.
    always_comb begin
        next_rdata    = 8'h00;
        next_rdata_oe = 1'b0;
        next_dtack    = 1'b0;
        if (ds_in && access_ok && sel != vgp_pkg::VGP_SEL_NONE) begin
            next_dtack = 1'b1;
            if (!write_in && sel == vgp_pkg::VGP_SEL_STAT) begin
                next_rdata    = port_b ? bus_line_status_b_in : bus_line_status_a_in;
                next_rdata_oe = 1'b1;
            end
        end
        next_common   = sys_rst || (common_reset_jumper_in && (soft_rst != 2'b00));
        // The page only reaches the bus while the DMA engine owns the address lines;
        // elsewhere the pins read zero and the enable stays low.
        // page onto upper address
        next_upper_oe = extended_mode_in && dma_addr_drive_in;
        next_upper    = next_upper_oe ? page : 8'h00;
    end

    // Register the outputs.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out                      <= 8'h00;
            rdata_oe_out                   <= 1'b0;
            dtack_out                      <= 1'b0;
            upper_address_out              <= 8'h00;
            upper_address_oe_out           <= 1'b0;
            privileged_access_only_out     <= 1'b1;
            system_controller_select_a_out <= 1'b0;
            system_controller_select_b_out <= 1'b0;
            port_reset_a_out               <= 1'b1;
            port_reset_b_out               <= 1'b1;
            common_reset_out               <= 1'b1;
        end else begin
            rdata_out                      <= next_rdata;
            rdata_oe_out                   <= next_rdata_oe;
            dtack_out                      <= next_dtack;
            upper_address_out              <= next_upper;
            upper_address_oe_out           <= next_upper_oe;
            privileged_access_only_out     <= priv;
            system_controller_select_a_out <= sc[0];
            system_controller_select_b_out <= sc[1];
            port_reset_a_out               <= port_rst[0];
            port_reset_b_out               <= port_rst[1];
            common_reset_out               <= next_common;
        end
    end

    // ************************************************************************
    // Checks.
    // ************************************************************************
    // The checks sample on the rising edge and sleep through the asynchronous reset;
    // registered outputs are compared one edge after their cause, two when the cause must first pass a state register.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_page_drive_out: assert property (
        (extended_mode_in && dma_addr_drive_in) |=> upper_address_oe_out && upper_address_out == $past(page))
        else $error("Page not driven during DMA address phase.");
    a_no_page_drive: assert property (
        !(extended_mode_in && dma_addr_drive_in) |=> !upper_address_oe_out)
        else $error("Upper address driven outside DMA.");
    a_page_shared_write: assert property (
        (strobe && write_in && sel == vgp_pkg::VGP_SEL_PAGE && !sys_rst) |=> page == $past(wdata_in))
        else $error("Page write from either port lost.");
    a_page_holds: assert property (
        !(strobe && write_in && sel == vgp_pkg::VGP_SEL_PAGE) |=> $stable(page))
        else $error("Page changed without write.");
    a_sysreset_clears_sc: assert property (
        sys_rst |=> sc == 2'b00 ##1 !system_controller_select_a_out && !system_controller_select_b_out)
        else $error("Controller select survived reset.");
    a_sysreset_resets: assert property (
        sys_rst |=> port_reset_a_out && port_reset_b_out && common_reset_out)
        else $error("SYSRESET did not force reset.");
    a_soft_reset_level: assert property (
        (strobe && write_in && sel == vgp_pkg::VGP_SEL_CFG && !sys_rst && wdata_in[1] && !port_b)
        |=> ##1 port_reset_a_out)
        else $error("Soft reset not asserted.");
    a_common_gate: assert property (
        (!sys_rst && !common_reset_jumper_in) |=> !common_reset_out)
        else $error("Shared reset without jumper.");
    a_status_read: assert property (
        (ds_in && access_ok && !write_in && sel == vgp_pkg::VGP_SEL_STAT && !port_b)
        |=> rdata_oe_out && rdata_out == $past(bus_line_status_a_in))
        else $error("Status read data wrong.");
    a_user_blocked: assert property (
        (priv && ds_in && !supervisor_in) |=> !dtack_out)
        else $error("User cycle accepted in supervisor mode.");

    // Select bits land on their own port only; a pending soft reset wins.
    a_sc_write_a: assert property (
        (strobe && write_in && sel == vgp_pkg::VGP_SEL_CFG && !port_b && !sys_rst && !soft_rst[0])
        |=> ##1 system_controller_select_a_out == $past(wdata_in[vgp_pkg::BIT_SYS_CTRL], 2))
        else $error("Controller select A not written.");
    a_sc_write_b: assert property (
        (strobe && write_in && sel == vgp_pkg::VGP_SEL_CFG && port_b && !sys_rst && !soft_rst[1])
        |=> ##1 system_controller_select_b_out == $past(wdata_in[vgp_pkg::BIT_SYS_CTRL], 2))
        else $error("Controller select B not written.");
    a_soft_clears_sc: assert property (
        (soft_rst != 2'b00) |=> (sc & $past(soft_rst)) == 2'b00)
        else $error("Controller select survived soft reset.");
    a_soft_release: assert property (
        (strobe && write_in && sel == vgp_pkg::VGP_SEL_CFG && !port_b && !sys_rst
         && !wdata_in[vgp_pkg::BIT_SOFT_RST]) |=> !soft_rst[0])
        else $error("Soft reset not released.");
    a_strap_load: assert property (
        sys_rst |=> ##1 privileged_access_only_out == $past(privilege_default_jumper_in, 2))
        else $error("Privilege not reloaded from jumper.");
    a_common_follows: assert property (
        (common_reset_jumper_in && soft_rst != 2'b00) |=> common_reset_out)
        else $error("Shared reset missing with jumper fitted.");
    a_status_read_b: assert property (
        (ds_in && access_ok && !write_in && sel == vgp_pkg::VGP_SEL_STAT && port_b)
        |=> rdata_oe_out && rdata_out == $past(bus_line_status_b_in))
        else $error("Status read data wrong on port B.");
    a_status_only_data: assert property (
        !(ds_in && access_ok && !write_in && sel == vgp_pkg::VGP_SEL_STAT)
        |=> !rdata_oe_out && rdata_out == 8'h00)
        else $error("Read data driven outside a status read.");
    a_unmapped_no_ack: assert property (
        (ds_in && sel == vgp_pkg::VGP_SEL_NONE) |=> !dtack_out)
        else $error("Unmapped cycle acknowledged.");

    c_page_write: cover property (strobe && write_in && sel == vgp_pkg::VGP_SEL_PAGE);
    c_status_read_b: cover property (rdata_oe_out && port_b);
    c_soft_reset: cover property (soft_rst[1] ##1 !soft_rst[1]);
    c_dma_drive: cover property (upper_address_oe_out);
    c_user_refused: cover property (priv && ds_in && !supervisor_in);
endmodule // vgp_port_config_regs
`default_nettype wire

// >>> vgp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************************
// Instrument bus side: control lines seen at the chip pins of each port.
// ****************************************************************************
module vgp_far_model (
    // Clock and freeze request.
    input  wire logic       clk_in,
    input  wire logic       hold_in,
    // Control lines per port, active high.
    output logic      [7:0] lines_a_out,
    output logic      [7:0] lines_b_out
);
    // Lines wander every cycle so that a stale read cannot pass.
    // raw lines only
    initial begin
        lines_a_out = 8'h00;
        lines_b_out = 8'h00;
        // The bench freezes the lines only around a status read.
        forever begin
            @(posedge clk_in);
            if (!hold_in) begin
                lines_a_out <= 8'($urandom);
                lines_b_out <= 8'($urandom);
            end
        end
    end
endmodule // vgp_far_model
`default_nettype wire

// >>> vme_gpib_port_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vme_gpib_port_config_regs_tb;
    logic       clk = 1'b0, arst_n = 1'b0, jmp = 1'b1, cjmp = 1'b0, sysrst_n = 1'b1;
    logic [9:0] addr = 10'h000;
    logic       ds = 1'b0, wr = 1'b0, privileged_access_only = 1'b1, ext = 1'b0, dma = 1'b0, hold = 1'b0;
    logic [7:0] wdata = 8'h00, la, lb, rdata, upper, v, rd;
    logic       oe, dtack, uoe, priv, sca, scb, rsta, rstb, crst, ack, rdoe;
    int         err_total = 0;
    int         total_checks = 0;
    // The clock runs at 10 MHz.
    always #50 clk = ~clk;
    vgp_far_model i_far (.clk_in(clk), .hold_in(hold), .lines_a_out(la), .lines_b_out(lb));
    vgp_port_config_regs i_dut (.clk_in(clk), .arst_n_in(arst_n), .privilege_default_jumper_in(jmp),
        .common_reset_jumper_in(cjmp), .sysreset_n_in(sysrst_n), .addr_in(addr), .ds_in(ds),
        .write_in(wr), .supervisor_in(privileged_access_only), .wdata_in(wdata), .rdata_out(rdata), .rdata_oe_out(oe),
        .dtack_out(dtack), .bus_line_status_a_in(la), .bus_line_status_b_in(lb),
        .extended_mode_in(ext), .dma_addr_drive_in(dma), .upper_address_out(upper),
        .upper_address_oe_out(uoe), .privileged_access_only_out(priv),
        .system_controller_select_a_out(sca), .system_controller_select_b_out(scb),
        .port_reset_a_out(rsta), .port_reset_b_out(rstb), .common_reset_out(crst));
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus cycle, entered just after a rising edge; strobe held until acknowledge, or for at most four cycles when none comes.
    task automatic acc(input logic [9:0] a, input logic w, input logic s, input logic [7:0] d,
                       input logic exp_ack);
        ack = 1'b0;
        addr <= a; wr <= w; privileged_access_only <= s; wdata <= d; ds <= 1'b1;
        for (int n = 0; n < 4 && !ack; n++) begin
            @(negedge clk);
            if (dtack === 1'b1) begin
                ack = 1'b1; rd = rdata; rdoe = oe;
            end
            @(posedge clk);
        end
        ds <= 1'b0;
        repeat (2) @(posedge clk);
        chk("dtack", 8'(ack), 8'(exp_ack));
    endtask
    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h1a12));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("priv", 8'(priv), 8'h01);
        chk("sc_a", 8'(sca), 8'h00);
        @(posedge clk);
        // Random pages through both ports and random status reads.
        // page reloaded each pass
        for (int k = 0; k < 8; k++) begin
            v = 8'($urandom);
            acc(k[0] ? vgp_pkg::OFS_PAGE_B : vgp_pkg::OFS_PAGE_A, 1'b1, 1'b1, v, 1'b1);
            ext <= (k < 2) | 1'($urandom); dma <= (k < 2) | 1'($urandom);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("page_oe", 8'(uoe), 8'(ext & dma));
            if (uoe === 1'b1) chk("page", upper, v);
            @(posedge clk);
            hold <= 1'b1;
            acc(k[1] ? vgp_pkg::OFS_LINE_STATUS_B : vgp_pkg::OFS_LINE_STATUS_A, 1'b0, 1'b1, 8'h00, 1'b1);
            chk("status", rd, k[1] ? lb : la);
            chk("status_oe", 8'(rdoe), 8'h01);
            hold <= 1'b0;
        end
        ext <= 1'b1; dma <= 1'b1;
        acc(vgp_pkg::OFS_PAGE_A, 1'b0, 1'b1, 8'h00, 1'b1);
        chk("page_read_oe", 8'(rdoe), 8'h00);
        acc(10'h0ff, 1'b1, 1'b1, 8'h55, 1'b0);
        // Select bits per port, reserved bits random.
        acc(vgp_pkg::OFS_CONFIG_TWO_A, 1'b1, 1'b1, {5'($urandom), 3'b001}, 1'b1);
        chk("sc_a", 8'(sca), 8'h01);
        chk("sc_b", 8'(scb), 8'h00);
        acc(vgp_pkg::OFS_CONFIG_TWO_B, 1'b1, 1'b1, {5'($urandom), 3'b101}, 1'b1);
        chk("sc_b", 8'(scb), 8'h01);
        chk("priv", 8'(priv), 8'h01);
        // A user cycle is refused while supervisor-only is set.
        acc(vgp_pkg::OFS_PAGE_A, 1'b1, 1'b0, ~v, 1'b0);
        chk("page_kept", upper, v);
        acc(vgp_pkg::OFS_CONFIG_TWO_A, 1'b1, 1'b1, 8'h01, 1'b1);
        acc(vgp_pkg::OFS_PAGE_A, 1'b1, 1'b0, ~v, 1'b1);
        chk("page_user", upper, ~v);
        // Soft reset from port A with the common jumper off and on.
        // hold shortened for run time
        for (int j = 0; j < 2; j++) begin
            cjmp <= j[0];
            acc(vgp_pkg::OFS_CONFIG_TWO_A, 1'b1, 1'b1, 8'h02, 1'b1);
            chk("rst_a", 8'(rsta), 8'h01);
            chk("common", 8'(crst), 8'(j));
            if (j == 0) chk("rst_b", 8'(rstb), 8'h00);
            acc(vgp_pkg::OFS_CONFIG_TWO_A, 1'b1, 1'b1, 8'h00, 1'b1);
            chk("rst_a_off", 8'(rsta), 8'h00);
            chk("common_off", 8'(crst), 8'h00);
        end
        // System reset reloads privilege from the jumper and clears selects.
        jmp <= 1'b0;
        acc(vgp_pkg::OFS_CONFIG_TWO_B, 1'b1, 1'b1, 8'h05, 1'b1);
        sysrst_n <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("sys_rst_a", 8'(rsta), 8'h01);
        chk("sys_rst_b", 8'(rstb), 8'h01);
        @(posedge clk);
        sysrst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("priv_jumper", 8'(priv), 8'h00);
        chk("sc_b_cleared", 8'(scb), 8'h00);
        report_and_stop();
    end
endmodule // vme_gpib_port_config_regs_tb
`default_nettype wire
